// File: common/rsb_pkg.sv
/*
 constants of the status/boot command link.
 assumes one 200 MHz core clock at both ends.
*/
package rsb_pkg;
	// opcodes
	localparam logic [7:0] OPC_BOOT  = 8'h01;
	localparam logic [7:0] OPC_PWRDN = 8'h11;
	// status byte bit positions
	localparam int ST_CTS_BIT = 7;
	localparam int ST_ERR_BIT = 6;
	localparam int ST_SQ_BIT  = 3;
	localparam int ST_RD_BIT  = 2;
	localparam int ST_STC_BIT = 0;
	localparam logic [7:0] STATUS_RST = 8'h80; // idle, clear to send
	// argument byte 1 bit positions
	localparam int A1_IEN_BIT   = 7;
	localparam int A1_PINOE_BIT = 6;
	localparam int A1_PATCH_BIT = 5;
	localparam int A1_XOSC_BIT  = 4;
	// function and audio mode codes
	localparam logic [3:0] FUNCTION_SELECT_FM_RX = 4'h0;
	localparam logic [3:0] FUNCTION_SELECT_QUERY = 4'hF;
	localparam logic [7:0] MODE_ANALOG  = 8'h05;
	localparam logic [7:0] MODE_DIGITAL = 8'hB0;
	localparam logic [7:0] MODE_BOTH    = 8'hB5;
	localparam logic [2:0] QUERY_RESP_BYTES = 3'h7;
	// timing
	localparam int CLK_PERIOD_NS  = 5;
	localparam int IRQ_LOW_MIN_NS = 1000;
	localparam int IRQ_LOW_CYC    = (IRQ_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BOOT_CYC_DEF   = 64; // boot work time, cycles
	localparam int CMD_CYC_DEF    = 8;  // other command work time, cycles
	// device and host states
	typedef enum logic [3:0] {DV_DOWN = 4'b0001, DV_ARGS = 4'b0010,
		DV_BUSY = 4'b0100, DV_UP = 4'b1000} rsb_dev_state_t;
	typedef enum logic [4:0] {HS_IDLE = 5'b00001, HS_CHECK = 5'b00010,
		HS_SEND = 5'b00100, HS_POLL = 5'b01000, HS_READ = 5'b10000} rsb_host_state_t;
	// audio mode legal for the chosen reference
	function automatic logic rsb_mode_ok(input logic xosc, input logic [7:0] mode);
		if (xosc)
			return mode == MODE_ANALOG;
		return (mode == MODE_ANALOG) || (mode == MODE_DIGITAL) || (mode == MODE_BOTH);
	endfunction
endpackage

// File: common/rsb_if.sv
/*
 byte-wide command/response link plus interrupt pin.
 assumes one clock; the pin has a pull-up.
*/
`timescale 1ns/100ps
interface rsb_if;
	logic       cmd_valid;   // command byte present
	logic       cmd_start;   // byte is an opcode
	logic [7:0] cmd_byte;    // command byte
	logic       rsp_rd;      // read one response byte
	logic       rsp_restart; // read restarts at status byte
	logic       rsp_valid;   // response byte present
	logic [7:0] rsp_byte;    // response byte
	logic       irq_out;     // pin drive value
	logic       irq_oe;      // pin driven
	logic       irq_level;   // resolved pin level
	// pull-up wins while undriven
	assign irq_level = irq_oe ? irq_out : 1'b1;
	modport device (input cmd_valid, cmd_start, cmd_byte, rsp_rd, rsp_restart,
		output rsp_valid, rsp_byte, irq_out, irq_oe);
	modport host (output cmd_valid, cmd_start, cmd_byte, rsp_rd, rsp_restart,
		input rsp_valid, rsp_byte, irq_level);
endinterface

// File: verilog/rsb_device.sv
/*
 receiver end: status byte, boot decode, identity answer, pin pulse.
 assumes the controller waits for clear-to-send.
*/
`timescale 1ns/100ps
// Summary of operation
// RQ1: status byte: send, error, three interrupt flags
// RQ2: send-ready low while busy, high when free
// RQ3: bit 3 set on signal quality event
// RQ4: bit 2 set on radio data event
// RQ5: bit 0 set on seek/tune done
// RQ6: opcode 01 boots from powerdown to powerup
// RQ7: two arguments; response one or eight bytes
// RQ8: query function answers identity, then powers down
// RQ9: function nibble: 0 receive, 15 query
// RQ10: arg1 bit 7 enables send-ready interrupt
// RQ11: arg1 bit 6 enables interrupt pin output
// RQ12: pin high, low at least 1 us per interrupt
// RQ13: arg1 bit 5 loads RAM without booting
// RQ14: arg1 bit 4 selects crystal, analog only
// RQ15: arg2 selects analog, digital or both outputs
// RQ16: boot done shown by send-ready and interrupt
// RQ17: controller powers down before changing function
// RQ18: controller checks library before patching
// RQ19: boot enable and property enable share one bit
// RQ20: query bytes: part, firmware, reserved, silicon, library
// RQ21: powerdown ignores all but the boot opcode
// RQ22: accepting a command clears send-ready
// RQ23: reserved function sets error, stays down
module rsb_device
	import rsb_pkg::*;
#(
	parameter int         BOOT_CYC       = BOOT_CYC_DEF,
	parameter int         CMD_CYC        = CMD_CYC_DEF,
	parameter bit         HAS_RADIO_DATA = 1'b1,
	parameter logic [7:0] PART_DIGITS    = 8'h11, // arbitrary value
	parameter logic [7:0] FW_MAJOR       = 8'h31, // arbitrary value
	parameter logic [7:0] FW_MINOR       = 8'h30, // arbitrary value
	parameter logic [7:0] SILICON_REV    = 8'h41, // arbitrary value
	parameter logic [7:0] LIBRARY_REV    = 8'h07  // arbitrary value
)(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	rsb_if.device           link,
	input  wire logic       signal_quality_event,
	input  wire logic       radio_data_event,
	input  wire logic       seek_tune_event,
	input  wire logic [2:0] irq_flag_clear,
	input  wire logic       prop_ien_write,
	input  wire logic       prop_ien_value,
	output logic            powered_up,
	output logic            patch_ram_mode,
	output logic            send_ready_irq_enable,
	output logic            irq_pin_output_enable,
	output logic            crystal_osc_enable,
	output logic [3:0]      function_select,
	output logic [7:0]      audio_output_mode,
	output logic            left_analog_out_en,
	output logic            digital_audio_en
);
	localparam logic [15:0] BOOT_N = 16'(BOOT_CYC);
	localparam logic [15:0] CMD_N  = 16'(CMD_CYC);
	localparam logic [7:0]  IRQ_N  = 8'(IRQ_LOW_CYC);

	rsb_dev_state_t state_r;    // command sequencer state
	logic        arg_idx_r;     // next argument slot
	logic [7:0]  arg1_r;        // boot argument 1
	logic [7:0]  arg2_r;        // boot argument 2
	logic [15:0] busy_cnt_r;    // work time remaining
	logic        boot_cmd_r;    // busy with a boot
	logic        from_up_r;     // boot arrived while powered
	logic        pwrdn_cmd_r;   // busy with a powerdown
	logic        cts_r;         // clear to send
	logic        err_r;         // error flag
	logic        sq_r;          // signal quality flag
	logic        rd_r;          // radio data flag
	logic        stc_r;         // seek/tune flag
	logic [2:0]  rsp_cnt_r;     // bytes after status
	logic [2:0]  rsp_idx_r;     // next byte to read
	logic [7:0]  irq_cnt_r;     // low pulse remaining
	logic        accept;        // opcode taken this cycle
	logic        busy_done;     // work ends this cycle
	logic        boot_bad;      // boot arguments refused
	logic        boot_ok;       // boot completes cleanly
	logic        boot_query;    // completing boot is a query
	logic        irq_fire;      // start a pin pulse
	logic [7:0]  status_byte;   // live status

	// opcode acceptance
	always_comb begin
		accept = 1'b0;
		if (link.cmd_valid && link.cmd_start) begin
			if (state_r == DV_DOWN)
				accept = (link.cmd_byte == OPC_BOOT); // RQ6 RQ21
			else if (state_r == DV_UP)
				accept = cts_r; // RQ2
		end
	end

	// end of work and boot checks
	always_comb begin
		busy_done  = (state_r == DV_BUSY) && (busy_cnt_r == 16'h0001);
		boot_query = (arg1_r[3:0] == FUNCTION_SELECT_QUERY);
		// refused boot arguments
		boot_bad   = from_up_r || ((arg1_r[3:0] != FUNCTION_SELECT_FM_RX) && !boot_query) // RQ9 RQ23
			|| !rsb_mode_ok(arg1_r[A1_XOSC_BIT], arg2_r); // RQ14 RQ15
		boot_ok    = busy_done && boot_cmd_r && !boot_bad;
		irq_fire   = busy_done && (boot_ok
			? (arg1_r[A1_IEN_BIT] && arg1_r[A1_PINOE_BIT]) // RQ12
			: (send_ready_irq_enable && irq_pin_output_enable)); // RQ16
	end

	// command sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= DV_DOWN;
			arg_idx_r   <= 1'b0;
			arg1_r      <= 8'h00;
			arg2_r      <= 8'h00;
			busy_cnt_r  <= 16'h0000;
			boot_cmd_r  <= 1'b0;
			from_up_r   <= 1'b0;
			pwrdn_cmd_r <= 1'b0;
			powered_up  <= 1'b0;
		end else begin
			case (state_r)
				DV_DOWN, DV_UP: begin
					if (accept) begin
						from_up_r   <= (state_r == DV_UP);
						boot_cmd_r  <= (link.cmd_byte == OPC_BOOT);
						pwrdn_cmd_r <= (link.cmd_byte == OPC_PWRDN);
						arg_idx_r   <= 1'b0;
						if (link.cmd_byte == OPC_BOOT) begin
							state_r <= DV_ARGS; // RQ7
						end else begin
							busy_cnt_r <= CMD_N;
							state_r    <= DV_BUSY;
						end
					end
				end
				DV_ARGS: begin
					// exactly two argument bytes
					if (link.cmd_valid && !link.cmd_start) begin
						arg_idx_r <= 1'b1;
						if (!arg_idx_r) begin
							arg1_r <= link.cmd_byte;
						end else begin
							arg2_r     <= link.cmd_byte; // RQ7
							busy_cnt_r <= BOOT_N;
							state_r    <= DV_BUSY;
						end
					end
				end
				DV_BUSY: begin
					busy_cnt_r <= busy_cnt_r - 16'h0001;
					if (busy_done) begin
						if (boot_cmd_r) begin
							// query answers then drops back to powerdown
							if (boot_ok && !boot_query) begin
								state_r    <= DV_UP; // RQ6
								powered_up <= 1'b1;
							end else begin
								state_r <= from_up_r ? DV_UP : DV_DOWN; // RQ8 RQ23
							end
						end else if (pwrdn_cmd_r) begin
							state_r    <= DV_DOWN;
							powered_up <= 1'b0;
						end else begin
							state_r <= DV_UP;
						end
					end
				end
				default: state_r <= DV_DOWN;
			endcase
		end
	end

	// send-ready and error bits
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cts_r <= 1'b1;
			err_r <= 1'b0;
		end else if (accept) begin
			cts_r <= 1'b0; // RQ22 RQ2
		end else if (busy_done) begin
			cts_r <= 1'b1; // RQ16
			err_r <= boot_cmd_r && boot_bad; // RQ23
		end
	end

	// sticky event flags; a set in the clearing cycle wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sq_r  <= 1'b0;
			rd_r  <= 1'b0;
			stc_r <= 1'b0;
		end else begin
			sq_r  <= signal_quality_event | (sq_r & ~irq_flag_clear[2]); // RQ3
			rd_r  <= HAS_RADIO_DATA & (radio_data_event | (rd_r & ~irq_flag_clear[1])); // RQ4
			stc_r <= seek_tune_event | (stc_r & ~irq_flag_clear[0]); // RQ5
		end
	end

	// configuration taken from a clean boot
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			send_ready_irq_enable <= 1'b0;
			irq_pin_output_enable <= 1'b0;
			crystal_osc_enable    <= 1'b0;
			function_select       <= FUNCTION_SELECT_FM_RX;
			audio_output_mode     <= 8'h00;
			patch_ram_mode        <= 1'b0;
			left_analog_out_en    <= 1'b0;
			digital_audio_en      <= 1'b0;
		end else if (boot_ok) begin
			send_ready_irq_enable <= arg1_r[A1_IEN_BIT]; // RQ10 RQ19
			irq_pin_output_enable <= arg1_r[A1_PINOE_BIT]; // RQ11
			crystal_osc_enable    <= arg1_r[A1_XOSC_BIT]; // RQ14
			function_select       <= arg1_r[3:0]; // RQ9
			audio_output_mode     <= arg2_r; // RQ15
			// patch load holds off the outputs until a later boot
			patch_ram_mode        <= !boot_query && arg1_r[A1_PATCH_BIT]; // RQ13
			left_analog_out_en    <= !boot_query && !arg1_r[A1_PATCH_BIT] && arg2_r[0]; // RQ15
			digital_audio_en      <= !boot_query && !arg1_r[A1_PATCH_BIT] && arg2_r[7]; // RQ15
		end else begin
			if (prop_ien_write)
				send_ready_irq_enable <= prop_ien_value; // RQ19
			if (busy_done && pwrdn_cmd_r) begin
				patch_ram_mode     <= 1'b0;
				left_analog_out_en <= 1'b0;
				digital_audio_en   <= 1'b0;
			end
		end
	end

	// identity bytes after the status byte
	function automatic logic [7:0] query_byte(input logic [2:0] idx);
		case (idx)
			3'h1:    return PART_DIGITS; // RQ20
			3'h2:    return FW_MAJOR;
			3'h3:    return FW_MINOR;
			3'h6:    return SILICON_REV;
			3'h7:    return LIBRARY_REV;
			default: return 8'h00; // reserved bytes
		endcase
	endfunction

	// reserved status bits read as zero
	assign status_byte = {cts_r, err_r, 2'b00, sq_r, rd_r, 1'b0, stc_r}; // RQ1

	// response reads
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_cnt_r      <= 3'h0;
			rsp_idx_r      <= 3'h0;
			link.rsp_valid <= 1'b0;
			link.rsp_byte  <= STATUS_RST;
		end else begin
			link.rsp_valid <= link.rsp_rd;
			if (accept)
				rsp_cnt_r <= 3'h0;
			else if (boot_ok && boot_query)
				rsp_cnt_r <= QUERY_RESP_BYTES; // RQ7 RQ8
			if (link.rsp_rd) begin
				if (link.rsp_restart || rsp_idx_r == 3'h0 || rsp_idx_r > rsp_cnt_r || !cts_r) begin
					link.rsp_byte <= status_byte; // RQ1
					rsp_idx_r     <= 3'h1;
				end else begin
					link.rsp_byte <= query_byte(rsp_idx_r); // RQ20
					rsp_idx_r     <= (rsp_idx_r == 3'h7) ? 3'h0 : rsp_idx_r + 3'h1;
				end
			end
		end
	end

	// interrupt pin: high at rest, low pulse per interrupt
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_cnt_r    <= 8'h00;
			link.irq_out <= 1'b1;
			link.irq_oe  <= 1'b0;
		end else begin
			link.irq_oe <= boot_ok ? arg1_r[A1_PINOE_BIT] : irq_pin_output_enable; // RQ11
			if (irq_fire) begin
				irq_cnt_r    <= IRQ_N;
				link.irq_out <= 1'b0; // RQ12
			end else if (irq_cnt_r != 8'h00) begin
				irq_cnt_r    <= irq_cnt_r - 8'h01;
				link.irq_out <= (irq_cnt_r == 8'h01); // RQ12
			end
		end
	end
endmodule // rsb_device

// File: verilog/rsb_host.sv
/*
 controller end: boot and powerdown requests, polls, identity read.
 assumes one request at a time.
*/
`timescale 1ns/100ps
module rsb_host
	import rsb_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	rsb_if.host              link,
	input  wire logic        req_boot,
	input  wire logic        req_pwrdn,
	input  wire logic [7:0]  boot_arg1,
	input  wire logic [7:0]  boot_arg2,
	output logic             busy,
	output logic             done,
	output logic             refused,
	output logic [7:0]       last_status,
	output logic [55:0]      query_bytes,
	output logic             lib_checked,
	output logic             irq_seen
);
	rsb_host_state_t state_r; // sequencer state
	logic [7:0] a1_r;         // held boot argument 1
	logic [7:0] a2_r;         // held boot argument 2
	logic       boot_r;       // current request is a boot
	logic       pend_boot_r;  // boot waits behind a powerdown
	logic       up_r;         // device believed powered
	logic [1:0] byte_r;       // bytes sent so far
	logic [2:0] left_r;       // response bytes still to read
	logic       wait_r;       // read issued, awaiting answer
	logic       irq_s1_r;     // pin sync stage one
	logic       irq_s2_r;     // pin sync stage two
	logic       irq_d_r;      // previous synced level

	// pin is from outside logic: two flops before use
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_s1_r <= 1'b1;
			irq_s2_r <= 1'b1;
			irq_d_r  <= 1'b1;
			irq_seen <= 1'b0;
		end else begin
			irq_s1_r <= link.irq_level;
			irq_s2_r <= irq_s1_r;
			irq_d_r  <= irq_s2_r;
			irq_seen <= irq_d_r && !irq_s2_r; // falling edge
		end
	end

	// request sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r          <= HS_IDLE;
			a1_r             <= 8'h00;
			a2_r             <= 8'h00;
			boot_r           <= 1'b0;
			pend_boot_r      <= 1'b0;
			up_r             <= 1'b0;
			byte_r           <= 2'h0;
			left_r           <= 3'h0;
			wait_r           <= 1'b0;
			busy             <= 1'b0;
			done             <= 1'b0;
			refused          <= 1'b0;
			last_status      <= STATUS_RST;
			query_bytes      <= 56'h0;
			lib_checked      <= 1'b0;
			link.cmd_valid   <= 1'b0;
			link.cmd_start   <= 1'b0;
			link.cmd_byte    <= 8'h00;
			link.rsp_rd      <= 1'b0;
			link.rsp_restart <= 1'b0;
		end else begin
			done             <= 1'b0;
			refused          <= 1'b0;
			link.cmd_valid   <= 1'b0;
			link.cmd_start   <= 1'b0;
			link.rsp_rd      <= 1'b0;
			link.rsp_restart <= 1'b0;
			case (state_r)
				HS_IDLE: begin
					if (req_boot && boot_arg1[A1_PATCH_BIT] && !lib_checked) begin
						refused <= 1'b1; // RQ18
					end else if (req_boot || req_pwrdn) begin
						a1_r        <= boot_arg1;
						a2_r        <= boot_arg2;
						// a powered device is stopped before a new function
						pend_boot_r <= req_boot && up_r; // RQ17
						boot_r      <= req_boot && !up_r;
						busy        <= 1'b1;
						state_r     <= HS_CHECK;
					end
				end
				HS_CHECK, HS_POLL: begin
					// poll the status byte until send-ready
					if (!wait_r) begin
						link.rsp_rd      <= 1'b1;
						link.rsp_restart <= 1'b1;
						wait_r           <= 1'b1;
					end else if (link.rsp_valid) begin
						wait_r      <= 1'b0;
						last_status <= link.rsp_byte;
						if (link.rsp_byte[ST_CTS_BIT]) begin // RQ2
							byte_r <= 2'h0;
							if (state_r == HS_CHECK) begin
								state_r <= HS_SEND;
							end else if (left_r != 3'h0) begin
								state_r <= HS_READ;
							end else if (pend_boot_r) begin
								pend_boot_r <= 1'b0;
								boot_r      <= 1'b1;
								state_r     <= HS_SEND;
							end else begin
								busy    <= 1'b0;
								done    <= 1'b1;
								state_r <= HS_IDLE;
							end
						end
					end
				end
				HS_SEND: begin
					link.cmd_valid <= 1'b1;
					link.cmd_start <= (byte_r == 2'h0);
					byte_r         <= byte_r + 2'h1;
					case (byte_r)
						2'h0:    link.cmd_byte <= boot_r ? OPC_BOOT : OPC_PWRDN;
						2'h1:    link.cmd_byte <= a1_r;
						default: link.cmd_byte <= a2_r;
					endcase
					if (!boot_r || byte_r == 2'h2) begin
						// query answers seven bytes, normal boot none
						left_r  <= (boot_r && a1_r[3:0] == FUNCTION_SELECT_QUERY) ? QUERY_RESP_BYTES : 3'h0; // RQ7
						up_r    <= boot_r && a1_r[3:0] == FUNCTION_SELECT_FM_RX;
						state_r <= HS_POLL;
					end
				end
				HS_READ: begin
					if (!wait_r) begin
						link.rsp_rd <= 1'b1;
						wait_r      <= 1'b1;
					end else if (link.rsp_valid) begin
						wait_r      <= 1'b0;
						query_bytes <= {query_bytes[47:0], link.rsp_byte}; // RQ20
						left_r      <= left_r - 3'h1;
						if (left_r == 3'h1) begin
							lib_checked <= 1'b1; // RQ18
							busy        <= 1'b0;
							done        <= 1'b1;
							state_r     <= HS_IDLE;
						end
					end
				end
				default: state_r <= HS_IDLE;
			endcase
		end
	end
endmodule // rsb_host

// File: testbench/rsb_link_asserts.sv
/*
 link checker: command bytes, status answers, pin.
 assumes core_clk at both ends.
*/
`timescale 1ns/100ps
module rsb_link_asserts
	import rsb_pkg::*;
#(
	parameter int BOOT_CYC = BOOT_CYC_DEF
)(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_start,
	input  wire logic [7:0] cmd_byte,
	input  wire logic       rsp_rd,
	input  wire logic       rsp_restart,
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_byte,
	input  wire logic       irq_level
);
	logic [7:0] since_r;   // edges since boot opcode, 0 = none
	logic [8:0] low_r;     // cycles the pin read low
	logic       rd_pend_r; // restart read in flight
	logic       cts_r;     // last send-ready seen by host
	wire        opc = cmd_valid && cmd_start;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// age of the last boot opcode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			since_r <= 8'h00;
		else if (opc)
			since_r <= (cmd_byte == OPC_BOOT) ? 8'h01 : 8'h00;
		else if (since_r != 8'h00 && since_r != 8'hFF)
			since_r <= since_r + 8'h01;
	end
	// pin low-time count
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			low_r <= 9'h000;
		else
			low_r <= irq_level ? 9'h000 : low_r + 9'h001;
	end
	// send-ready as last polled
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_r <= 1'b0;
			cts_r     <= 1'b0;
		end else begin
			rd_pend_r <= rsp_rd && rsp_restart;
			if (opc)
				cts_r <= 1'b0;
			else if (rd_pend_r && rsp_valid)
				cts_r <= rsp_byte[ST_CTS_BIT];
		end
	end
	a_read_answered: assert property (rsp_rd |=> rsp_valid) else $error("read not answered");
	a_no_stray_answer: assert property (!rsp_rd |=> !rsp_valid) else $error("answer without read");
	a_reserved_bits_zero: assert property (rsp_rd && rsp_restart |=> rsp_byte[5:4] == 2'h0 && !rsp_byte[1])
		else $error("reserved status bits set");
	a_boot_two_args: assert property (opc && cmd_byte == OPC_BOOT |=>
		cmd_valid && !cmd_start ##1 cmd_valid && !cmd_start ##1 !cmd_valid) else $error("boot args wrong");
	a_send_after_ready: assert property (opc |-> cts_r) else $error("opcode sent while busy");
	a_busy_after_boot: assert property (rsp_rd && rsp_restart && since_r != 8'h00 && since_r <= BOOT_CYC + 1
		|=> !rsp_byte[ST_CTS_BIT]) else $error("ready too early");
	a_ready_after_boot: assert property (rsp_rd && rsp_restart && since_r >= BOOT_CYC + 3 && since_r != 8'hFF
		|=> rsp_byte[ST_CTS_BIT]) else $error("ready too late");
	a_irq_at_done: assert property ($fell(irq_level) && since_r != 8'h00 |-> since_r == BOOT_CYC + 3)
		else $error("pin fell off done");
	a_irq_low_width: assert property ($rose(irq_level) |-> low_r == IRQ_LOW_CYC) else $error("pin pulse width");
	c_boot_sent: cover property (opc && cmd_byte == OPC_BOOT);
	c_pin_pulse: cover property ($fell(irq_level));
	c_plain_read: cover property (rsp_rd && !rsp_restart);
endmodule // rsb_link_asserts

// File: testbench/testbench.sv
/*
 bench: host and receiver on one link, a second receiver hand-driven.
 assumes a 200 MHz core_clk.
*/
`timescale 1ns/100ps
module testbench;
	import rsb_pkg::*;
	localparam int BC = 16; // shortened boot time
	localparam logic [55:0] ID = 56'h5A3234_0000_430C; // arbitrary value
	logic        core_clk, rst_n, sq_ev, rd_ev, st_ev, prop_wr, prop_val;
	logic [2:0]  flag_clr;
	logic        req_boot, req_pwrdn, done, lib_checked, irq_seen, irq_hit, up_b;
	logic [7:0]  arg1, arg2, last_status, rb, mode_a;
	logic [55:0] query_bytes;
	logic        up_a, patch_a, ien_a, oe_a, xo_a, ana_a, dig_a;
	logic [3:0]  function_select_a;
	int          failures, comparisons;
	rsb_if link();
	rsb_if link_b();
	rsb_device #(.BOOT_CYC(BC), .CMD_CYC(4), .PART_DIGITS(ID[55:48]), .FW_MAJOR(ID[47:40]), .FW_MINOR(ID[39:32]),
		.SILICON_REV(ID[15:8]), .LIBRARY_REV(ID[7:0])) u_rsb_device (.core_clk(core_clk), .rst_n(rst_n),
		.link(link), .signal_quality_event(sq_ev), .radio_data_event(rd_ev), .seek_tune_event(st_ev),
		.irq_flag_clear(flag_clr), .prop_ien_write(prop_wr), .prop_ien_value(prop_val), .powered_up(up_a),
		.patch_ram_mode(patch_a), .send_ready_irq_enable(ien_a), .irq_pin_output_enable(oe_a),
		.crystal_osc_enable(xo_a), .function_select(function_select_a), .audio_output_mode(mode_a),
		.left_analog_out_en(ana_a), .digital_audio_en(dig_a));
	rsb_device #(.BOOT_CYC(BC), .CMD_CYC(4)) u_rsb_device_b (.core_clk(core_clk), .rst_n(rst_n),
		.link(link_b), .signal_quality_event(sq_ev), .radio_data_event(rd_ev), .seek_tune_event(st_ev),
		.irq_flag_clear(flag_clr), .prop_ien_write(prop_wr), .prop_ien_value(prop_val), .powered_up(up_b),
		.patch_ram_mode(), .send_ready_irq_enable(), .irq_pin_output_enable(), .crystal_osc_enable(),
		.function_select(), .audio_output_mode(), .left_analog_out_en(), .digital_audio_en());
	rsb_host u_rsb_host (.core_clk(core_clk), .rst_n(rst_n), .link(link), .req_boot(req_boot),
		.req_pwrdn(req_pwrdn), .boot_arg1(arg1), .boot_arg2(arg2), .busy(), .done(done), .refused(),
		.last_status(last_status), .query_bytes(query_bytes), .lib_checked(lib_checked), .irq_seen(irq_seen));
	rsb_link_asserts #(.BOOT_CYC(BC)) u_rsb_link_asserts (.core_clk(core_clk), .rst_n(rst_n),
		.cmd_valid(link.cmd_valid), .cmd_start(link.cmd_start), .cmd_byte(link.cmd_byte), .rsp_rd(link.rsp_rd),
		.rsp_restart(link.rsp_restart), .rsp_valid(link.rsp_valid), .rsp_byte(link.rsp_byte),
		.irq_level(link.irq_level));
	// free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// sticky copy of the host's pin event
	always @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			irq_hit <= 1'b0;
		else if (irq_seen === 1'b1)
			irq_hit <= 1'b1;
	task automatic chk_val(input logic [55:0] got, input logic [55:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_val({55'h0, got}, {55'h0, exp}, what);
	endtask
	task automatic close_out;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick;
		@(posedge core_clk) #1;
	endtask
	// one host request, bounded wait for done
	task automatic host_req(input logic boot, input logic [7:0] a1, input logic [7:0] a2);
		int i;
		tick();
		{req_boot, req_pwrdn, arg1, arg2} = {boot, !boot, a1, a2};
		tick();
		{req_boot, req_pwrdn} = 2'b00;
		for (i = 0; i < 3000 && done !== 1'b1; i++)
			tick();
		chk_bit(done, 1'b1, "host done");
	endtask
	// hand-driven byte on the second link; data scrambled when idle
	task automatic b_send(input logic st, input logic [7:0] b);
		tick();
		{link_b.cmd_valid, link_b.cmd_start, link_b.cmd_byte} = {1'b1, st, b};
		tick();
		{link_b.cmd_valid, link_b.cmd_start, link_b.cmd_byte} = {2'b00, ~b};
	endtask
	task automatic b_read(input logic rs);
		tick();
		{link_b.rsp_rd, link_b.rsp_restart} = {1'b1, rs};
		tick();
		{link_b.rsp_rd, link_b.rsp_restart} = 2'b00;
		chk_bit(link_b.rsp_valid, 1'b1, "answer strobe");
		rb = link_b.rsp_byte;
	endtask
	// boot on the second link, polled early and late
	task automatic b_boot(input logic [7:0] a1, input logic [7:0] a2);
		b_send(1'b1, OPC_BOOT);
		b_send(1'b0, a1);
		b_send(1'b0, a2);
		b_read(1'b1);
		chk_bit(rb[ST_CTS_BIT], 1'b0, "busy after boot");
		repeat (BC + 4) @(posedge core_clk);
		b_read(1'b1);
		chk_bit(rb[ST_CTS_BIT], 1'b1, "ready after boot");
	endtask
	task automatic t_query;
		host_req(1'b1, 8'hCF, MODE_ANALOG);
		chk_val(query_bytes, ID, "identity");
		chk_bit(up_a, 1'b0, "down after query");
		chk_bit(lib_checked, 1'b1, "library read");
		chk_val(last_status[7:6], 2'b10, "query status");
		chk_bit(ien_a, 1'b1, "irq enable");
		chk_bit(link.irq_oe, 1'b1, "pin driven");
		repeat (20) @(posedge core_clk);
		chk_bit(irq_hit, 1'b1, "pin event");
		chk_bit(link.irq_level, 1'b0, "pin low");
		repeat (250) @(posedge core_clk);
		chk_bit(link.irq_level, 1'b1, "pin high again");
		$display("test query done");
	endtask
	task automatic t_fm;
		host_req(1'b1, 8'h00, MODE_BOTH);
		chk_bit(up_a, 1'b1, "powered up");
		chk_val(function_select_a, FUNCTION_SELECT_FM_RX, "function");
		chk_val({mode_a, ana_a, dig_a}, {MODE_BOTH, 2'b11}, "audio mode");
		chk_val({ien_a, oe_a, patch_a, xo_a}, 4'h0, "arg1 bits clear");
		chk_bit(last_status[ST_ERR_BIT], 1'b0, "no error");
		// property write reaches the same enable
		tick();
		{prop_wr, prop_val} = 2'b11;
		tick();
		prop_wr = 1'b0;
		tick();
		chk_bit(ien_a, 1'b1, "shared enable");
		$display("test fm done");
	endtask
	// reboots while up go through a powerdown first
	task automatic t_swap;
		host_req(1'b1, 8'h10, MODE_ANALOG);
		chk_val({up_a, xo_a, ana_a, dig_a}, 4'hE, "crystal boot");
		host_req(1'b1, 8'h20, MODE_ANALOG);
		chk_bit(patch_a, 1'b1, "patch mode");
		host_req(1'b0, 8'h00, 8'h00);
		chk_val({up_a, patch_a}, 2'b00, "powered down");
		$display("test swap done");
	endtask
	task automatic t_flags;
		int k;
		int pos [3] = '{ST_SQ_BIT, ST_RD_BIT, ST_STC_BIT};
		for (k = 0; k < 3; k++) begin
			tick();
			{sq_ev, rd_ev, st_ev} = 3'b100 >> k;
			tick();
			{sq_ev, rd_ev, st_ev} = 3'b000;
			b_read(1'b1);
			chk_val(rb, STATUS_RST | (8'h01 << pos[k]), "flag set");
			flag_clr = 3'b100 >> k;
			tick();
			flag_clr = 3'b000;
			b_read(1'b1);
			chk_val(rb, STATUS_RST, "flag cleared");
		end
		$display("test flags done");
	endtask
	task automatic t_down;
		b_send(1'b1, OPC_PWRDN);
		b_read(1'b1);
		chk_val(rb, STATUS_RST, "ignored in powerdown");
		b_boot(8'h05, MODE_ANALOG);
		chk_val({rb[ST_ERR_BIT], up_b}, 2'b10, "reserved function");
		b_boot(8'h10, MODE_DIGITAL);
		chk_val({rb[ST_ERR_BIT], up_b}, 2'b10, "crystal with digital");
		b_boot(8'h00, MODE_ANALOG);
		chk_val({rb, up_b}, {STATUS_RST, 1'b1}, "good boot");
		$display("test down done");
	endtask
	initial begin
		{sq_ev, rd_ev, st_ev, prop_wr, prop_val, req_boot, req_pwrdn} = 7'h00;
		{flag_clr, arg1, arg2, failures, comparisons} = '0;
		{link_b.cmd_valid, link_b.cmd_start, link_b.cmd_byte, link_b.rsp_rd, link_b.rsp_restart} = 12'h000;
		rst_n = 1'b0;
		repeat (10) @(posedge core_clk);
		#1 rst_n = 1'b1;
		t_query();
		t_fm();
		t_swap();
		t_flags();
		t_down();
		close_out();
	end
	// hang guard, several times the expected run
	initial begin
		#50000;
		failures++;
		$display("FAIL %0t watchdog expired", $time);
		close_out();
	end
endmodule // testbench
